// ### pkg/dtv_pkg.sv
// Package: register map, field layouts, reset values and types of the dual timer block.
package dtv_pkg;

  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_CTRL0   = 4'h0;
  localparam logic [3:0] OFF_PRE0    = 4'h1;
  localparam logic [3:0] OFF_LOAD0   = 4'h2;
  localparam logic [3:0] OFF_COUNT0  = 4'h3;
  localparam logic [3:0] OFF_CTRL1   = 4'h4;
  localparam logic [3:0] OFF_PRE1    = 4'h5;
  localparam logic [3:0] OFF_LOAD1   = 4'h6;
  localparam logic [3:0] OFF_COUNT1  = 4'h7;
  localparam logic [3:0] OFF_MODE1   = 4'h8;
  localparam logic [3:0] OFF_IMASK   = 4'h9;
  localparam logic [3:0] OFF_IPRIO   = 4'ha;
  localparam logic [3:0] OFF_IREQ    = 4'hb;
  localparam logic [3:0] OFF_PORTCFG = 4'hc;
  localparam logic [3:0] OFF_PORTIN  = 4'hd;

  // Timer control bits.
  localparam int CTL_START   = 0;
  localparam int CTL_STOP    = 1;
  localparam int CTL_RELOAD  = 2;
  localparam int CTL_CONT    = 3;
  // Interrupt mask: bit 7 is the global enable.
  localparam int MASK_GLOBAL = 7;
  localparam int NUM_REQ     = 6;
  localparam int REQ_TMR0    = 4;
  localparam int REQ_TMR1    = 5;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_PRE  = 6'h00;
  // Internal count source for the second timer: processor clock divided by four.
  localparam int INT_DIV = 4;

  typedef enum logic [1:0] {
    DTV_EXT_CLOCK, DTV_TRIG_RETRIG, DTV_TRIG_ONCE, DTV_GATE
  } dtv_extmode_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } dtv_bus_s;

  typedef struct packed {
    logic       grant;
    logic [2:0] reqNum;
    logic [7:0] vecAddr;
  } dtv_irq_s;

endpackage

// ### rtl/dtv_timer.sv
// Design: dual 8-bit timer with prescalers and six-source prioritised interrupt logic.
`timescale 1ns/1ps
// Function
// R1: Two independent 8-bit down counters, each with its own 6-bit prescaler.
// R2: Second prescaler takes internal or external source; first is internal only.
// R3: Prescaler divides its input by any integer from 1 to 64.
// R4: Counter decrements per prescaler output from a load value meaning 1 to 256.
// R5: Counter and prescaler end of count raise request five or six.
// R6: Commands start, stop, continue from current count, restart from load value.
// R7: One-shot halts at zero; continuous mode reloads and keeps counting.
// R8: Counter reads are harmless at any time; prescalers read as zero.
// R9: Second timer source is clock divided by four or the external line.
// R10: External line acts as clock, retrigger, one-shot trigger, or gate.
// R11: Six sources: three falling edges, one rising edge, two timer events.
// R12: Mask register enables requests globally and individually.
// R13: Priority register selects which pending request is serviced.
// R14: Grant disables further interrupts; core saves state and branches to vector.
// R15: Each vector is two bytes holding a 16-bit service address.
// R16: Request flags stay visible when masked, for polled operation.
// R17: Three input lines, each selectable as digital or analog input.
// R18: Vector pairs sit at 0,1 through 10,11 in request order.
// R19: Port lines are synchronised before edge detection; one event per edge. Analog lines take analogCompare without synchronisation.
// R20: Pending flag stays until granted or cleared by software.
module dtv_timer
  import dtv_pkg::*;
#(
  parameter int PRE_W = 6,
  parameter int CNT_W = 8
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Register port
  input  wire dtv_pkg::dtv_bus_s bus,
  output logic [7:0]           rdata,
  // Input port lines (a, b, c) and analog comparator results
  input  wire logic [2:0]      inputLines,
  input  wire logic [2:0]      analogCompare,
  output logic [2:0]           analogSelect,
  // Processor interrupt handshake
  input  wire logic            intAck,
  input  wire logic            intReenable,
  output logic                 intRequest,
  output dtv_pkg::dtv_irq_s    irq
);
  import dtv_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Register port decode.
  wire wrCtrl0 = bus.wr && bus.addr == OFF_CTRL0;
  wire wrCtrl1 = bus.wr && bus.addr == OFF_CTRL1;
  wire wrIreq  = bus.wr && bus.addr == OFF_IREQ;

  logic [PRE_W-1:0] preLoad0, preLoad1;
  logic [CNT_W-1:0] cntLoad0, cntLoad1;
  logic [1:0]       modeReg;
  logic             srcExt;
  logic [7:0]       maskReg;
  logic [2:0]       prioReg;
  logic [NUM_REQ-1:0] pend;
  logic             intEnable;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      preLoad0 <= RST_PRE;
      preLoad1 <= RST_PRE;
      cntLoad0 <= RST_BYTE;
      cntLoad1 <= RST_BYTE;
      modeReg <= 2'b00;
      srcExt <= 1'b0;
      maskReg <= RST_BYTE;
      prioReg <= 3'b000;
      analogSelect <= 3'b000;
    end else if (bus.wr) begin
      unique case (bus.addr)
        OFF_PRE0:    preLoad0 <= bus.wdata[PRE_W-1:0];
        OFF_PRE1:    preLoad1 <= bus.wdata[PRE_W-1:0];
        OFF_LOAD0:   cntLoad0 <= bus.wdata;
        OFF_LOAD1:   cntLoad1 <= bus.wdata;
        OFF_MODE1: begin
          modeReg <= bus.wdata[1:0];
          srcExt <= bus.wdata[2]; // R2 R9
        end
        OFF_IMASK:   maskReg <= bus.wdata; // R12
        OFF_IPRIO:   prioReg <= bus.wdata[2:0]; // R13
        OFF_PORTCFG: analogSelect <= bus.wdata[2:0]; // R17
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detectors.
  logic [2:0] sync1, sync2;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1 <= 3'b111;
      sync2 <= 3'b111;
    end else begin
      sync1 <= inputLines; // R19
      sync2 <= sync1;
    end
  end
  // Analog lines take the comparator result so both input kinds raise requests.
  wire [2:0] lineVal  = (sync2 & ~analogSelect) | (analogCompare & analogSelect); // R17
  logic [2:0] linePrev;
  always_ff @(posedge clk) begin
    if (!rst_n) linePrev <= 3'b111;
    else linePrev <= lineVal;
  end
  wire [2:0] fallEdge = linePrev & ~lineVal; // R19
  wire       riseB    = ~linePrev[1] & lineVal[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Second timer source: divide by four or the external line.
  logic [1:0] div4;
  always_ff @(posedge clk) begin
    if (!rst_n) div4 <= 2'b00;
    else div4 <= div4 + 2'b01;
  end
  wire intTick = div4 == 2'(INT_DIV - 1); // R9
  wire extLine = lineVal[0];
  wire extRise = ~linePrev[0] & extLine;
  dtv_extmode_e extMode;
  assign extMode = dtv_extmode_e'(modeReg);
  wire extClockMode = srcExt && extMode == DTV_EXT_CLOCK;
  wire tick1 = extClockMode ? extRise
             : (srcExt && extMode == DTV_GATE) ? (intTick && extLine) // R10
             : intTick;
  wire trigger1 = srcExt && (extMode == DTV_TRIG_RETRIG || extMode == DTV_TRIG_ONCE) && extRise;

  ////////////////////////////////////////////////////////////////////////////////
  // Timer cores.
  logic [CNT_W-1:0] count0, count1;
  logic             run0, run1, end0, end1;

  dtv_counter #(.PRE_W(PRE_W), .CNT_W(CNT_W)) uTimer0 (
    .clk      (clk),
    .rst_n    (rst_n),
    .tick     (intTick),
    .ctlWr    (wrCtrl0),
    .ctl      (bus.wdata[3:0]),
    .trigger  (1'b0),
    .retrig   (1'b0),
    .preLoad  (preLoad0),
    .cntLoad  (cntLoad0),
    .count    (count0),
    .running  (run0),
    .endCount (end0)
  );

  dtv_counter #(.PRE_W(PRE_W), .CNT_W(CNT_W)) uTimer1 (
    .clk      (clk),
    .rst_n    (rst_n),
    .tick     (tick1),
    .ctlWr    (wrCtrl1),
    .ctl      (bus.wdata[3:0]),
    .trigger  (trigger1),
    .retrig   (extMode == DTV_TRIG_RETRIG),
    .preLoad  (preLoad1),
    .cntLoad  (cntLoad1),
    .count    (count1),
    .running  (run1),
    .endCount (end1)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt requests, masking and priority.
  // Order: fall b, fall c, fall a, rise b, first timer, second timer.
  wire [NUM_REQ-1:0] evt = {end1, end0, riseB, fallEdge[0], fallEdge[2], fallEdge[1]}; // R11 R5
  wire [NUM_REQ-1:0] active = pend & maskReg[NUM_REQ-1:0] & {NUM_REQ{maskReg[MASK_GLOBAL]}};
  logic [2:0] winner;
  logic       anyActive;
  always_comb begin
    winner = 3'd0;
    anyActive = 1'b0;
    for (int k = NUM_REQ - 1; k >= 0; k--) begin
      if (active[(int'(prioReg) + k) % NUM_REQ]) begin
        winner = 3'((int'(prioReg) + k) % NUM_REQ); // R13
        anyActive = 1'b1;
      end
    end
  end
  wire doGrant = intAck && intRequest;
  wire [NUM_REQ-1:0] grantMask = doGrant ? (NUM_REQ'(1) << winner) : '0;
  wire [NUM_REQ-1:0] swClr = wrIreq ? ~bus.wdata[NUM_REQ-1:0] : '0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend <= '0;
      intEnable <= 1'b1;
      irq <= '0;
    end else begin
      pend <= (pend & ~swClr & ~grantMask) | evt; // R20 R16
      if (doGrant) intEnable <= 1'b0; // R14
      else if (intReenable) intEnable <= 1'b1;
      irq.grant <= doGrant;
      irq.reqNum <= winner;
      irq.vecAddr <= {4'h0, winner, 1'b0}; // R15 R18
    end
  end
  assign intRequest = anyActive && intEnable;

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe.
  logic [7:0] rmux;
  always_comb begin
    unique case (bus.addr)
      OFF_PRE0:    rmux = RST_BYTE; // R8
      OFF_PRE1:    rmux = RST_BYTE;
      OFF_CTRL0:   rmux = {7'h00, run0};
      OFF_CTRL1:   rmux = {7'h00, run1};
      OFF_LOAD0:   rmux = cntLoad0;
      OFF_LOAD1:   rmux = cntLoad1;
      OFF_COUNT0:  rmux = count0; // R8
      OFF_COUNT1:  rmux = count1;
      OFF_MODE1:   rmux = {5'h00, srcExt, modeReg};
      OFF_IMASK:   rmux = maskReg;
      OFF_IPRIO:   rmux = {5'h00, prioReg};
      OFF_IREQ:    rmux = {2'b00, pend};
      OFF_PORTCFG: rmux = {5'h00, analogSelect};
      OFF_PORTIN:  rmux = {5'h00, lineVal};
      default:     rmux = RST_BYTE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) rdata <= RST_BYTE;
    else if (bus.rd) rdata <= rmux;
    else rdata <= RST_BYTE;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_grant_clears_flag: assert property (@(posedge clk) disable iff (!rst_n) // R20
    doGrant && !evt[winner] |=> !pend[$past(winner)]) else $error("grant left flag set");
  a_grant_blocks_int: assert property (@(posedge clk) disable iff (!rst_n) // R14
    doGrant && !intReenable |=> !intRequest) else $error("request after grant");
  a_masked_flag_kept: assert property (@(posedge clk) disable iff (!rst_n) // R16
    !maskReg[MASK_GLOBAL] && pend[REQ_TMR0] && !(wrIreq && !bus.wdata[REQ_TMR0])
      |=> pend[REQ_TMR0]) else $error("timer flag lost");
  a_vector_pair: assert property (@(posedge clk) disable iff (!rst_n) // R18
    doGrant |=> irq.vecAddr == 8'({$past(winner), 1'b0})) else $error("vector wrong");
  a_fall_event: assert property (@(posedge clk) disable iff (!rst_n) // R11
    linePrev[0] && !lineVal[0] |=> pend[2]) else $error("fall a lost");
  a_rise_event: assert property (@(posedge clk) disable iff (!rst_n) // R11
    !linePrev[1] && lineVal[1] |=> pend[3]) else $error("rise b lost");
  a_global_mask: assert property (@(posedge clk) disable iff (!rst_n) // R12
    !maskReg[MASK_GLOBAL] |-> !intRequest) else $error("masked request");
  a_timer0_event: assert property (@(posedge clk) disable iff (!rst_n) // R5
    end0 |=> pend[REQ_TMR0]) else $error("timer event lost");
  a_read_latency: assert property (@(posedge clk) disable iff (!rst_n) // R8
    bus.rd && bus.addr == OFF_PRE0 |=> rdata == RST_BYTE) else $error("prescaler read");

endmodule // dtv_timer

// One prescaled down counter with command and mode handling.
module dtv_counter #(
  parameter int PRE_W = 6,
  parameter int CNT_W = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Count source and control
  input  wire logic             tick,
  input  wire logic             ctlWr,
  input  wire logic [3:0]       ctl,
  input  wire logic             trigger,
  input  wire logic             retrig,
  input  wire logic [PRE_W-1:0] preLoad,
  input  wire logic [CNT_W-1:0] cntLoad,
  // State
  output logic [CNT_W-1:0]      count,
  output logic                  running,
  output logic                  endCount
);
  import dtv_pkg::*;
  logic [PRE_W-1:0] pre;
  logic             cont;
  // Load zero means 256 and prescale zero means 64: terminal value is 1 wraps through 0.
  wire preEnd = pre == PRE_W'(1); // R3
  wire cntEnd = count == CNT_W'(1); // R4
  wire step   = running && tick;
  wire restartCmd = ctlWr && ctl[CTL_RELOAD];
  wire trigLoad = trigger && (retrig || !running); // R10
  assign endCount = step && preEnd && cntEnd; // R5

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre <= RST_PRE;
      count <= '0;
      running <= 1'b0;
      cont <= 1'b0;
    end else if (restartCmd || trigLoad) begin
      pre <= preLoad; // R6
      count <= cntLoad;
      running <= 1'b1;
      if (ctlWr) cont <= ctl[CTL_CONT];
    end else if (ctlWr) begin
      running <= ctl[CTL_START] && !ctl[CTL_STOP]; // R6
      cont <= ctl[CTL_CONT];
    end else if (step) begin
      pre <= preEnd ? preLoad : pre - PRE_W'(1); // R1
      if (preEnd) begin
        if (cntEnd) begin
          count <= cont ? cntLoad : CNT_W'(0); // R7
          running <= cont;
        end else begin
          count <= count - CNT_W'(1); // R4
        end
      end
    end
  end
endmodule // dtv_counter

// ### sim/dtv_core_model.sv
// Partner model: processor core end of the interrupt handshake.
`timescale 1ns/1ps
module dtv_core_model (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Interrupt handshake
  input  wire logic              intRequest,
  input  wire dtv_pkg::dtv_irq_s irq,
  output logic                   intAck,
  output logic                   intReenable,
  // Bench side
  input  wire logic [1:0]        ackDelay,
  output logic [2:0]             lastNum,
  output logic [7:0]             lastVec,
  output int                     grants
);
  import dtv_pkg::*;
  logic [1:0] waitCnt;
  logic [3:0] svcCnt;
  // A long service lets the bench poll the flags before interrupts are enabled again.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      intAck      <= 1'b0;
      intReenable <= 1'b0;
      waitCnt     <= 2'h0;
      svcCnt      <= 4'h0;
      lastNum     <= 3'h0;
      lastVec     <= 8'h00;
      grants      <= 0;
    end else begin
      intAck      <= 1'b0;
      intReenable <= (svcCnt == 4'h1);
      if (svcCnt != 4'h0) begin
        svcCnt <= svcCnt - 4'h1;
      end
      if (intRequest && !intAck && svcCnt == 4'h0 && !irq.grant) begin
        waitCnt <= waitCnt + 2'h1;
        if (waitCnt == ackDelay) begin
          intAck  <= 1'b1;
          waitCnt <= 2'h0;
        end
      end
      if (irq.grant) begin
        lastNum <= irq.reqNum;
        lastVec <= irq.vecAddr;
        grants  <= grants + 1;
        svcCnt  <= 4'hc;
      end
    end
  end
endmodule // dtv_core_model

// ### sim/test_dual_timer_with_vectored_irq.sv
// Testbench: register, timer, port edge and interrupt scenarios for the dual timer.
`timescale 1ns/1ps
module test_dual_timer_with_vectored_irq;
  import dtv_pkg::*;
  logic       clk, rst_n, intAck, intReenable, intRequest;
  dtv_bus_s   bus;
  dtv_irq_s   irq;
  logic [7:0] rdata, lastVec, d, e;
  logic [2:0] inputLines, analogCompare, analogSelect, lastNum;
  logic [1:0] ackDelay;
  logic [31:0] seed;
  logic [3:0] offs [12] = '{OFF_CTRL0, OFF_PRE0, OFF_LOAD0, OFF_COUNT0, OFF_CTRL1, OFF_PRE1,
                            OFF_LOAD1, OFF_COUNT1, OFF_MODE1, OFF_IMASK, OFF_IPRIO, OFF_IREQ};
  logic [2:0] seqL [4] = '{3'h5, 3'h1, 3'h0, 3'h2};
  int         miscompares, check_count, grants, cyc, t0, ld, pr, g;

  dtv_timer i_dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .inputLines(inputLines), .analogCompare(analogCompare), .analogSelect(analogSelect),
    .intAck(intAck), .intReenable(intReenable), .intRequest(intRequest), .irq(irq));
  dtv_core_model i_core (.clk(clk), .rst_n(rst_n), .intRequest(intRequest), .irq(irq),
    .intAck(intAck), .intReenable(intReenable), .ackDelay(ackDelay), .lastNum(lastNum),
    .lastVec(lastVec), .grants(grants));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken just then.
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic waitBit(input int b, input int lim);
    for (int i = 0; i < lim; i++) begin
      rd(OFF_IREQ, d);
      if (d[b] === 1'b1) return;
    end
    miscompares++;
    $display("CHECK FAILED at %0t: wait for request %0d ran out", $time, b);
    stop_test();
  endtask
  task automatic lines(input logic [2:0] v);
    @(posedge clk);
    inputLines <= v;
    repeat (6) @(posedge clk);
  endtask
  task automatic pulseA(input int n);
    for (int i = 0; i < n; i++) begin
      lines(3'h6);
      lines(3'h7);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'he02cb291;
    rst_n = 1'b0;
    bus = '0;
    inputLines = 3'h7;
    analogCompare = 3'h0;
    ackDelay = 2'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (offs[i]) begin
      rd(offs[i], d);
      chk(d, RST_BYTE, "reset value");
    end
    wr(4'hf, 8'h5a);
    rd(4'hf, d);
    chk(d, 8'h00, "unmapped read");
    wr(OFF_PRE0, 8'h3f);
    rd(OFF_PRE0, d);
    chk(d, 8'h00, "prescaler read");
    $display("Test registers done");
    for (int k = 0; k < 4; k++) begin
      ld = (k == 0) ? 1 : 1 + int'(xs() % 6);
      pr = (k == 1) ? 64 : 1 + int'(xs() % 4);
      wr(OFF_PRE0, pr[7:0] & 8'h3f);
      wr(OFF_LOAD0, ld[7:0]);
      wr(OFF_IREQ, 8'h00);
      wr(OFF_CTRL0, 8'h05);
      t0 = cyc;
      waitBit(REQ_TMR0, 1600);
      t0 = cyc - t0 - ld * pr * INT_DIV;
      chk((t0 > -6 && t0 < 8) ? 8'h01 : 8'h00, 8'h01, "timer0 period");
      wr(OFF_IREQ, 8'h00);
      repeat (ld * pr * INT_DIV + 20) @(posedge clk);
      rd(OFF_IREQ, d);
      chk(d & 8'h10, 8'h00, "one-shot halts");
    end
    wr(OFF_PRE0, 8'h00);
    wr(OFF_LOAD0, 8'h02);
    wr(OFF_CTRL0, 8'h0d);
    for (int k = 0; k < 2; k++) begin
      wr(OFF_IREQ, 8'h00);
      waitBit(REQ_TMR0, 400);
    end
    wr(OFF_CTRL0, 8'h02);
    rd(OFF_COUNT0, e);
    repeat (600) @(posedge clk);
    rd(OFF_COUNT0, d);
    chk(d, e, "stopped count");
    wr(OFF_CTRL0, 8'h04);
    rd(OFF_COUNT0, d);
    chk(d, 8'h02, "restart from load");
    wr(OFF_CTRL0, 8'h02);
    $display("Test first timer done");
    wr(OFF_MODE1, 8'h04);
    wr(OFF_PRE1, 8'h01);
    wr(OFF_LOAD1, 8'h02);
    wr(OFF_IREQ, 8'h00);
    // Start alone would continue from the reset count, so the load value is applied too.
    wr(OFF_CTRL1, 8'h05);
    repeat (40) @(posedge clk);
    rd(OFF_IREQ, d);
    chk(d & 8'h20, 8'h00, "no external clock");
    pulseA(3);
    waitBit(REQ_TMR1, 10);
    for (int m = 1; m < 3; m++) begin
      wr(OFF_MODE1, 8'h04 | m[7:0]);
      wr(OFF_CTRL1, 8'h02);
      wr(OFF_IREQ, 8'h00);
      pulseA(1);
      waitBit(REQ_TMR1, 20);
    end
    wr(OFF_MODE1, 8'h07);
    lines(3'h6);
    wr(OFF_IREQ, 8'h00);
    wr(OFF_CTRL1, 8'h05);
    repeat (40) @(posedge clk);
    rd(OFF_IREQ, d);
    chk(d & 8'h20, 8'h00, "gate closed");
    lines(3'h7);
    waitBit(REQ_TMR1, 20);
    wr(OFF_CTRL1, 8'h02);
    wr(OFF_MODE1, 8'h00);
    $display("Test second timer done");
    foreach (seqL[i]) begin
      wr(OFF_IREQ, 8'h00);
      lines(seqL[i]);
      rd(OFF_IREQ, d);
      chk(d, 8'h01 << i, "port edge");
    end
    wr(OFF_IREQ, 8'h00);
    repeat (8) @(posedge clk);
    rd(OFF_IREQ, d);
    chk(d, 8'h00, "single event");
    $display("Test port edges done");
    for (int p = 0; p < 4; p++) begin
      wr(OFF_IMASK, 8'h00);
      wr(OFF_IREQ, 8'h00);
      lines(3'h7);
      foreach (seqL[i]) lines(seqL[i]);
      wr(OFF_IPRIO, p[7:0]);
      wr(OFF_IMASK, 8'h0f);
      rd(OFF_IREQ, d);
      chk(d, 8'h0f, "flags while masked");
      chk({7'h0, intRequest}, 8'h00, "global disable");
      ackDelay <= 2'(xs());
      g = grants;
      wr(OFF_IMASK, 8'h8f);
      for (int i = 0; i < 30 && grants == g; i++) @(posedge clk) #1;
      chk(8'(grants - g), 8'h01, "grant count");
      chk({5'h0, lastNum}, p[7:0], "granted request");
      chk(lastVec, 8'(2 * p), "vector address");
      chk({7'h0, intRequest}, 8'h00, "disabled in service");
      rd(OFF_IREQ, d);
      chk(d, 8'h0f & ~(8'h01 << p), "grant clears flag");
    end
    wr(OFF_IMASK, 8'h00);
    $display("Test interrupts done");
    wr(OFF_PORTCFG, 8'h05);
    @(posedge clk);
    chk({5'h0, analogSelect}, 8'h05, "analog select");
    analogCompare <= 3'(xs());
    inputLines <= 3'(xs());
    repeat (6) @(posedge clk);
    rd(OFF_PORTIN, d);
    chk(d, {5'h0, (analogCompare & 3'h5) | (inputLines & 3'h2)}, "port input");
    $display("Test input port done");
    stop_test();
  end
endmodule // test_dual_timer_with_vectored_irq
